// file: shared/spc_pkg.sv
// Shared constants and types of the stepper position controller link
package spc_pkg;
    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int DATA_W = 48;
    localparam int RESP_W = 32;
    localparam int POS_W  = 16;
    localparam int SEC_W  = 11;

    // ------------------------------------------------------------------
    // Commands, modes, states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_STATUS_PRIMARY, CMD_STATUS_SECONDARY, CMD_MOVE_TO_TARGET, CMD_GO_SAFE_POSITION,
        CMD_REFERENCE_SEARCH, CMD_IMMEDIATE_STOP, CMD_SET_MOTOR_PARAM
    } spc_cmd_type;
    typedef enum logic [1:0] {MODE_HALF, MODE_QUARTER, MODE_EIGHTH, MODE_SIXTEENTH} spc_mode_type;
    typedef enum logic [3:0] {
        ST_INACTIVE, ST_STOPPED, ST_GOTO, ST_REF_LEG1, ST_REF_LEG2, ST_REF_SAFE,
        ST_DEADLOCK, ST_STOP_WAIT, ST_SHUTDOWN
    } spc_state_type;

    // ------------------------------------------------------------------
    // Command data field positions
    // ------------------------------------------------------------------
    localparam int F_POS_LSB  = 0;   // Target of a move
    localparam int F_ACC_LSB  = 0;
    localparam int F_VMAX_LSB = 4;
    localparam int F_VMIN_LSB = 8;
    localparam int F_MODE_LSB = 12;
    localparam int F_SEC_LSB  = 16;
    localparam int F_LEG1_LSB = 16;  // Reference search first leg
    localparam int F_LEG2_LSB = 32;  // Reference search second leg

    // ------------------------------------------------------------------
    // Primary status bit positions
    // ------------------------------------------------------------------
    localparam int S_SWITCH   = 0;
    localparam int S_EDEF     = 1;
    localparam int S_PFAIL    = 2;
    localparam int S_THERMAL  = 3;
    localparam int S_UNDERV   = 4;
    localparam int S_SHUTDOWN = 5;
    localparam int S_BUSY     = 6;
    localparam int S_ACTIVE   = 7;
    localparam int S_ACC_LSB  = 8;
    localparam int S_MODE_LSB = 12;

    // ------------------------------------------------------------------
    // Reset values and timing counts
    // ------------------------------------------------------------------
    localparam logic [15:0] POS_RESET   = 16'h0000;
    localparam logic [3:0]  ACC_RESET   = 4'h0;
    localparam logic [3:0]  VMAX_RESET  = 4'h0;
    localparam logic [3:0]  VMIN_RESET  = 4'h0;
    localparam logic [3:0]  ACC_TOP     = 4'hf;
    localparam logic [10:0] SEC_DISABLE = 11'h400;  // Most negative value, -1024
    localparam logic [2:0]  STEP_SHIFT  = 3'h2;     // Step interval unit, 4 link cycles
    localparam logic [7:0]  LINK_HALF   = 8'h02;    // clk cycles per link clock half period
endpackage

// file: shared/spc_link_if.sv
// Link between host and stepper controller: toggle handshake on the link clock
`timescale 1ns/1ps
interface spc_link_if;
    logic                           link_clk;
    logic                           req_toggle;
    spc_pkg::spc_cmd_type           req_code;
    logic [spc_pkg::DATA_W-1:0]     req_data;
    logic                           ack_toggle;
    logic [spc_pkg::RESP_W-1:0]     resp_data;

    modport host (output link_clk, output req_toggle, output req_code, output req_data,
                  input ack_toggle, input resp_data);
    modport dev  (input link_clk, input req_toggle, input req_code, input req_data,
                  output ack_toggle, output resp_data);
endinterface

// file: verilog/spc_sync.sv
// Two flip-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps
module spc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] first;
        logic [W-1:0] second;
    } spc_sync_type;

    spc_sync_type st;
    spc_sync_type next_st;

    // First stage feeds only the second stage
    always_comb begin
        next_st.first  = d;
        next_st.second = st.first;
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign q = st.second;
endmodule

// file: verilog/spc_device.sv
// Stepper position controller: device end, clocked by the link clock
//
// Operation
// - Host keeps acceleration unchanged during motion
// - Acceleration from 16-entry index, vmax dependent
// - Positions wrap per stepping mode width
// - Move command sets target; secondary read reports
// - Stored 11-bit secure position, go command
// - Secure unit scaled by stepping mode
// - Primary read shows switch; open reads zero
// - Switch changes trigger no automatic action
// - Faults force immediate motor shutdown
// - Electrical and pump failures set flags
// - Shutdown: bridges off, target takes actual
// - Link stays fully working during shutdown
// - Leave shutdown: causes clear, then primary read
// - Exit: hold current, clocks, pump enabled
// - Inactive after power-on until primary read
// - Host advised to reference after faults
// - Reference first leg uses ramp, given speeds
// - Second leg constant speed at minimum velocity
// - Zero actual, then go secure if enabled
// - Reference search ignores all but status reads and stop
// - Host avoids equal reference positions
// - Deadlock exits by stop then primary read
`timescale 1ns/1ps
module spc_device (
    spc_link_if.dev     link,
    input  wire logic       srst,
    input  wire logic       thermal_trip,
    input  wire logic       undervoltage_shutdown_level,
    input  wire logic       electrical_fault,
    input  wire logic       pump_fault,
    input  wire logic [1:0] switch_sense_pin,
    output logic            bridge_enable,
    output logic            motor_clk_enable,
    output logic            pump_enable,
    output logic            step_pulse,
    output logic            step_dir
);
    import spc_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        spc_state_type state;
        logic [15:0]   actual;
        logic [15:0]   target;
        logic [15:0]   leg2;
        logic [3:0]    acc;
        logic [3:0]    vmax;
        logic [3:0]    vmin;
        spc_mode_type  mode;
        logic [10:0]   secure;
        logic          edef;
        logic          pfail;
        logic          req_seen;
        logic          ack;
        logic [31:0]   resp;
        logic [7:0]    tick;
        logic [3:0]    speed;
        logic [4:0]    ramp;
        logic          step;
        logic          dir;
    } spc_dev_type;

    localparam spc_dev_type DEV_RESET = '{
        state: ST_INACTIVE, actual: POS_RESET, target: POS_RESET, leg2: POS_RESET,
        acc: ACC_RESET, vmax: VMAX_RESET, vmin: VMIN_RESET, mode: MODE_HALF,
        secure: SEC_DISABLE, default: '0};

    spc_dev_type st;
    spc_dev_type next_st;
    logic [7:0]  sy;
    logic        rst;
    logic        req_ev;
    logic        cause;
    logic        moving;
    logic [7:0]  gap;
    logic [4:0]  ramp_gap;
    logic [7:0]  prod;
    logic [3:0]  start;
    logic [15:0] sec_pos;
    logic [15:0] leg1;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Sign-extend from the mode's position width so counts wrap in range
    function automatic logic [15:0] wrap_pos(input logic [15:0] p, input spc_mode_type m);
        unique case (m)
            MODE_HALF:    wrap_pos = {{3{p[12]}}, p[12:0]};
            MODE_QUARTER: wrap_pos = {{2{p[13]}}, p[13:0]};
            MODE_EIGHTH:  wrap_pos = {p[14], p[14:0]};
            default:      wrap_pos = p;
        endcase
    endfunction

    // Pins and the bench reset come from outside the link domain
    spc_sync #(.W(8)) u_sync (
        .clk (link.link_clk),
        .d   ({srst, link.req_toggle, thermal_trip, undervoltage_shutdown_level,
               electrical_fault, pump_fault, switch_sense_pin}),
        .q   (sy)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.step = 1'b0;
        rst     = sy[7];
        req_ev  = sy[6] != st.req_seen;
        cause   = |sy[5:2];
        moving  = st.state inside {ST_GOTO, ST_REF_LEG1, ST_REF_LEG2, ST_REF_SAFE};
        gap     = {3'h0, 5'h10 - {1'b0, st.speed}} << STEP_SHIFT;
        ramp_gap = {1'b0, ACC_TOP - st.acc} + {3'h0, st.vmax[3:2]};
        prod    = {4'h0, st.vmax} * {4'h0, st.vmin};
        start   = (st.vmin == 4'h0) ? st.vmax : prod[7:4];
        sec_pos = wrap_pos({{5{st.secure[10]}}, st.secure} << (3'h2 + {1'b0, st.mode}),
                           st.mode);
        leg1    = wrap_pos(link.req_data[F_LEG1_LSB +: POS_W], st.mode);

        // Motion: one step per interval toward the target
        if (moving) begin
            if (st.actual == st.target) begin
                unique case (st.state)
                    ST_REF_LEG1: begin
                        next_st.target = st.leg2;
                        next_st.speed  = start;
                        next_st.state  = ST_REF_LEG2;
                    end
                    ST_REF_LEG2: begin
                        next_st.actual = POS_RESET;
                        if (st.secure != SEC_DISABLE) begin
                            next_st.target = sec_pos;
                            next_st.speed  = start;
                            next_st.state  = ST_REF_SAFE;
                        end else begin
                            next_st.state = ST_STOPPED;
                        end
                    end
                    default: next_st.state = ST_STOPPED;
                endcase
            end else if (st.tick == 8'h00) begin
                next_st.step   = 1'b1;
                next_st.dir    = $signed(st.target) > $signed(st.actual);
                next_st.actual = wrap_pos(next_st.dir ? st.actual + 16'h0001
                                                      : st.actual - 16'h0001, st.mode);
                next_st.tick   = gap;
                // Second leg has no ramp; others ramp up toward vmax
                if (st.state != ST_REF_LEG2 && st.speed < st.vmax) begin
                    if (st.ramp >= ramp_gap) begin
                        next_st.speed = st.speed + 4'h1;
                        next_st.ramp  = 5'h00;
                    end else begin
                        next_st.ramp = st.ramp + 5'h01;
                    end
                end
            end else begin
                next_st.tick = st.tick - 8'h01;
            end
        end

        // Commands are answered in every state, shutdown included
        if (req_ev) begin
            next_st.req_seen = sy[6];
            next_st.ack      = ~st.ack;
            next_st.resp     = '0;
            unique case (link.req_code)
                CMD_STATUS_PRIMARY: begin
                    next_st.resp[S_SWITCH]   = |sy[1:0];
                    next_st.resp[S_EDEF]     = st.edef;
                    next_st.resp[S_PFAIL]    = st.pfail;
                    next_st.resp[S_THERMAL]  = sy[5];
                    next_st.resp[S_UNDERV]   = sy[4];
                    next_st.resp[S_SHUTDOWN] = st.state == ST_SHUTDOWN;
                    next_st.resp[S_BUSY]     = moving;
                    next_st.resp[S_ACTIVE]   = st.state != ST_INACTIVE;
                    next_st.resp[S_ACC_LSB +: 4] = st.acc;
                    next_st.resp[S_MODE_LSB +: 2] = st.mode;
                    next_st.edef  = 1'b0;
                    next_st.pfail = 1'b0;
                    if (st.state == ST_INACTIVE && !cause) begin
                        next_st.state = ST_STOPPED;
                    end
                    if (st.state == ST_SHUTDOWN && !cause) begin
                        next_st.state = ST_STOPPED;
                    end
                    if (st.state == ST_STOP_WAIT) begin
                        next_st.state = ST_STOPPED;
                    end
                end
                CMD_STATUS_SECONDARY: next_st.resp[POS_W-1:0] = st.actual;
                CMD_MOVE_TO_TARGET: begin
                    if (st.state inside {ST_STOPPED, ST_GOTO}) begin
                        next_st.target = wrap_pos(link.req_data[F_POS_LSB +: POS_W], st.mode);
                        if (st.state == ST_STOPPED) begin
                            next_st.speed = start;
                            next_st.ramp  = 5'h00;
                            next_st.state = ST_GOTO;
                        end
                    end
                end
                CMD_GO_SAFE_POSITION: begin
                    if (st.state inside {ST_STOPPED, ST_GOTO} && st.secure != SEC_DISABLE) begin
                        next_st.target = sec_pos;
                        if (st.state == ST_STOPPED) begin
                            next_st.speed = start;
                            next_st.ramp  = 5'h00;
                            next_st.state = ST_GOTO;
                        end
                    end
                end
                CMD_REFERENCE_SEARCH: begin
                    if (st.state == ST_STOPPED) begin
                        next_st.vmax   = link.req_data[F_VMAX_LSB +: 4];
                        next_st.vmin   = link.req_data[F_VMIN_LSB +: 4];
                        next_st.target = leg1;
                        next_st.leg2   = wrap_pos(link.req_data[F_LEG2_LSB +: POS_W], st.mode);
                        next_st.speed  = link.req_data[F_VMIN_LSB +: 4] == 4'h0
                                       ? link.req_data[F_VMAX_LSB +: 4] : 4'h0;
                        next_st.ramp   = 5'h00;
                        // Equal positions never finish a leg: hang until stopped
                        if (leg1 == st.actual || leg1 == next_st.leg2) begin
                            next_st.state = ST_DEADLOCK;
                        end else begin
                            next_st.state = ST_REF_LEG1;
                        end
                    end
                end
                CMD_IMMEDIATE_STOP: begin
                    if (moving) begin
                        next_st.target = st.actual;
                        next_st.state  = ST_STOPPED;
                    end else if (st.state == ST_DEADLOCK) begin
                        next_st.state = ST_STOP_WAIT;
                    end
                end
                CMD_SET_MOTOR_PARAM: begin
                    // Reference search locks its settings until it ends
                    if (!(st.state inside {ST_REF_LEG1, ST_REF_LEG2, ST_REF_SAFE, ST_DEADLOCK})) begin
                        next_st.acc    = link.req_data[F_ACC_LSB +: 4];
                        next_st.vmax   = link.req_data[F_VMAX_LSB +: 4];
                        next_st.vmin   = link.req_data[F_VMIN_LSB +: 4];
                        next_st.mode   = spc_mode_type'(link.req_data[F_MODE_LSB +: 2]);
                        next_st.secure = link.req_data[F_SEC_LSB +: SEC_W];
                    end
                end
                default: next_st.resp = '0;
            endcase
        end

        // Fault flags: a new fault beats the clear by a primary read
        if (sy[3]) begin
            next_st.edef = 1'b1;
        end
        if (sy[2]) begin
            next_st.pfail = 1'b1;
        end

        // Shutdown beats all but reset; the switch deliberately feeds nothing here
        if (cause && !(st.state inside {ST_INACTIVE, ST_SHUTDOWN})) begin
            next_st.state  = ST_SHUTDOWN;
            next_st.target = next_st.actual;
        end

        if (rst) begin
            next_st = DEV_RESET;
        end
    end

    always_ff @(posedge link.link_clk) begin
        st <= next_st;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Bridges off in shutdown and before activation; hold current when stopped
    assign bridge_enable    = !(st.state inside {ST_INACTIVE, ST_SHUTDOWN});
    assign motor_clk_enable = bridge_enable;
    assign pump_enable      = bridge_enable;
    assign step_pulse       = st.step;
    assign step_dir         = st.dir;
    assign link.ack_toggle  = st.ack;
    assign link.resp_data   = st.resp;
endmodule

// file: verilog/spc_host.sv
// Stepper position controller: host end, drives the link clock
`timescale 1ns/1ps
module spc_host (
    spc_link_if.host                  link,
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic                 cmd_valid,
    output logic                      cmd_ready,
    input  wire spc_pkg::spc_cmd_type cmd_code,
    input  wire logic [47:0]          cmd_data,
    output logic                      cmd_reject,
    output logic                      resp_valid,
    output logic [31:0]               resp_data
);
    import spc_pkg::*;

    typedef enum {H_BOOT, H_IDLE, H_WAIT} spc_hstate_type;

    typedef struct packed {
        spc_hstate_type state;
        logic [7:0]     div;
        logic           lclk;
        logic           req;
        spc_cmd_type    code;
        logic [47:0]    data;
        logic           ack_seen;
        logic [31:0]    resp;
        logic           resp_valid;
        logic           reject;
        logic           busy;
        logic [15:0]    last_actual;
    } spc_host_type;

    spc_host_type st;
    spc_host_type next_st;
    logic         ack_sy;
    logic         bad;

    // Answer toggle comes from the link domain
    spc_sync #(.W(1)) u_sync (
        .clk (clk),
        .d   (link.ack_toggle),
        .q   (ack_sy)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.resp_valid = 1'b0;
        next_st.reject     = 1'b0;
        // Free-running divided link clock
        if (st.div == LINK_HALF - 8'h01) begin
            next_st.div  = 8'h00;
            next_st.lclk = ~st.lclk;
        end else begin
            next_st.div = st.div + 8'h01;
        end
        // Acceleration change refused while moving; equal reference legs refused
        bad = (cmd_code == CMD_SET_MOTOR_PARAM && st.busy)
            || (cmd_code == CMD_REFERENCE_SEARCH
                && (cmd_data[F_LEG1_LSB +: POS_W] == st.last_actual
                    || cmd_data[F_LEG1_LSB +: POS_W] == cmd_data[F_LEG2_LSB +: POS_W]));
        unique case (st.state)
            H_BOOT: begin
                // Wake the device with a primary read before anything else
                next_st.code  = CMD_STATUS_PRIMARY;
                next_st.req   = ~st.req;
                next_st.state = H_WAIT;
            end
            H_IDLE: begin
                if (cmd_valid) begin
                    if (bad) begin
                        next_st.reject = 1'b1;
                    end else begin
                        next_st.code  = cmd_code;
                        next_st.data  = cmd_data;
                        next_st.req   = ~st.req;
                        next_st.state = H_WAIT;
                    end
                end
            end
            H_WAIT: begin
                if (ack_sy != st.ack_seen) begin
                    next_st.ack_seen   = ack_sy;
                    next_st.resp       = link.resp_data;
                    next_st.resp_valid = 1'b1;
                    next_st.state      = H_IDLE;
                    if (st.code == CMD_STATUS_PRIMARY) begin
                        next_st.busy = link.resp_data[S_BUSY];
                    end
                    if (st.code == CMD_STATUS_SECONDARY) begin
                        next_st.last_actual = link.resp_data[POS_W-1:0];
                    end
                end
            end
        endcase
        if (srst) begin
            next_st = '{state: H_BOOT, code: CMD_STATUS_PRIMARY, default: '0};
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign cmd_ready       = st.state == H_IDLE;
    assign cmd_reject      = st.reject;
    assign resp_valid      = st.resp_valid;
    assign resp_data       = st.resp;
    assign link.link_clk   = st.lclk;
    assign link.req_toggle = st.req;
    assign link.req_code   = st.code;
    assign link.req_data   = st.data;
endmodule

// file: test/spc_link_assertions.sv
// Link protocol assertions for the host and device ends
`timescale 1ns/1ps
module spc_link_assertions (
    input wire logic                       link_clk,
    input wire logic                       srst,
    input wire logic                       req_toggle,
    input wire spc_pkg::spc_cmd_type       req_code,
    input wire logic [spc_pkg::DATA_W-1:0] req_data,
    input wire logic                       ack_toggle,
    input wire logic [spc_pkg::RESP_W-1:0] resp_data
);
    import spc_pkg::*;
    // ----------------------------------------
    // Answer events seen on the link clock
    // ----------------------------------------
    default clocking @(posedge link_clk); endclocking
    default disable iff (srst);
    sequence s_answer;
        $changed(ack_toggle);
    endsequence
    sequence s_primary;
        s_answer ##0 req_code == CMD_STATUS_PRIMARY;
    endsequence
    AST_ACK_PAIRS: assert property (s_answer |-> $past(req_toggle != ack_toggle))
        else $error("answer without request");
    AST_ACK_BOUND: assert property ($changed(req_toggle) |-> ##[1:8] s_answer)
        else $error("request not answered");
    AST_RESP_WITH_ACK: assert property ($changed(resp_data) |-> s_answer)
        else $error("answer data moved alone");
    AST_REQ_HELD: assert property ((req_toggle != ack_toggle) && $stable(req_toggle) |->
        $stable(req_code) && $stable(req_data)) else $error("request changed while pending");
    AST_NONSTATUS_ZERO: assert property (s_answer ##0 req_code > CMD_STATUS_SECONDARY |->
        resp_data == '0) else $error("command answer not zero");
    AST_POS_RANGE: assert property (s_answer ##0 req_code == CMD_STATUS_SECONDARY |->
        resp_data[31:16] == 16'h0000) else $error("position field too wide");
    AST_MOVE_ACTIVE: assert property (s_primary |-> !resp_data[S_BUSY] || resp_data[S_ACTIVE])
        else $error("moving while inactive");
    AST_SHUTDOWN_IDLE: assert property (s_primary ##0 resp_data[S_SHUTDOWN] |->
        !resp_data[S_BUSY]) else $error("moving in shutdown");
endmodule

// file: test/test_stepper_position_controller.sv
// Bench joining host and device ends over the link
`timescale 1ns/1ps
module test_stepper_position_controller;
    import spc_pkg::*;
    logic        clk = 1'b0, srst = 1'b1, cmd_valid = 1'b0, thermal_trip = 1'b0;
    logic        undervoltage_shutdown_level = 1'b0, electrical_fault = 1'b0, pump_fault = 1'b0;
    logic        cmd_ready, cmd_reject, resp_valid, bridge_enable, rej;
    logic        motor_clk_enable, pump_enable;
    logic [1:0]  switch_sense_pin = 2'h0;
    logic [47:0] cmd_data = '0;
    logic [31:0] resp_data, r;
    spc_cmd_type cmd_code = CMD_STATUS_PRIMARY;
    int          n_fail = 0, samples_checked = 0, cyc = 0;
    spc_link_if  link ();
    spc_host u_spc_host (.link, .clk, .srst, .cmd_valid, .cmd_ready, .cmd_code, .cmd_data,
        .cmd_reject, .resp_valid, .resp_data);
    spc_device u_spc_device (.link, .srst, .thermal_trip, .undervoltage_shutdown_level,
        .electrical_fault, .pump_fault, .switch_sense_pin, .bridge_enable,
        .motor_clk_enable, .pump_enable, .step_pulse(), .step_dir());
    spc_link_assertions u_spc_link_assertions (.link_clk(link.link_clk), .srst,
        .req_toggle(link.req_toggle), .req_code(link.req_code), .req_data(link.req_data),
        .ack_toggle(link.ack_toggle), .resp_data(link.resp_data));
    // --------------------------------
    // Clock, hang guard and helpers
    // --------------------------------
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // One command at a falling edge; waits for its answer or refusal
    task automatic send(input spc_cmd_type c, input logic [47:0] d);
        for (int i = 0; i < 300 && cmd_ready !== 1'b1; i++) @(negedge clk);
        cmd_code = c;
        cmd_data = d;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        for (int i = 0; i < 60 && resp_valid !== 1'b1 && cmd_reject !== 1'b1; i++) @(negedge clk);
        rej = cmd_reject;
        r = resp_data;
    endtask
    // Polls primary status until motion ends, then reads the position
    task automatic settle();
        for (int i = 0; i < 400; i++) begin
            send(CMD_STATUS_PRIMARY, '0);
            if (r[S_BUSY] === 1'b0) break;
        end
        send(CMD_STATUS_SECONDARY, '0);
    endtask
    task automatic t_switch();
        for (int k = 0; k < 3; k++) begin
            switch_sense_pin = 2'(k);
            repeat (20) @(negedge clk);
            send(CMD_STATUS_PRIMARY, '0);
            chk(32'(r[S_ACTIVE]), 32'h1);
            chk(32'(r[S_SWITCH]), 32'(k != 0));
        end
        settle();
        chk(r, 32'h0);
    endtask
    task automatic t_move();
        send(CMD_SET_MOTOR_PARAM, {21'h0, 11'h001, 4'h1, 4'h0, 4'hf, 4'hf});
        send(CMD_MOVE_TO_TARGET, 48'h5);
        settle();
        chk(r, 32'h5);
        send(CMD_GO_SAFE_POSITION, '0);
        settle();
        chk(r, 32'h8);
        send(CMD_MOVE_TO_TARGET, 48'h3fff);
        settle();
        chk(r, 32'hffff);
        send(CMD_STATUS_PRIMARY, '0);
        chk(32'(r[11:8]), 32'hf);
    endtask
    task automatic t_ref();
        send(CMD_REFERENCE_SEARCH, {16'h0004, 16'h0004, 16'h00f0});
        chk(32'(rej), 32'h1);
        send(CMD_REFERENCE_SEARCH, {16'h0002, 16'h0004, 16'h0ff0});
        send(CMD_MOVE_TO_TARGET, 48'h20);
        send(CMD_STATUS_PRIMARY, '0);
        send(CMD_SET_MOTOR_PARAM, {21'h0, 11'h001, 4'h1, 4'h0, 4'hf, 4'hf});
        chk(32'(rej), 32'h1);
        settle();
        chk(r, 32'h8);
        send(CMD_MOVE_TO_TARGET, 48'h7f);
        send(CMD_IMMEDIATE_STOP, '0);
        settle();
        chk(32'(r < 32'h7f), 32'h1);
    endtask
    // Each shutdown cause in turn: enter, report, clear, leave
    task automatic t_fault();
        for (int k = 0; k < 4; k++) begin
            {undervoltage_shutdown_level, thermal_trip, pump_fault, electrical_fault} = 4'h1 << k;
            repeat (20) @(negedge clk);
            chk(32'(bridge_enable), 32'h0);
            send(CMD_STATUS_PRIMARY, '0);
            chk(32'(r[S_SHUTDOWN] & r[S_EDEF + k]), 32'h1);
            {undervoltage_shutdown_level, thermal_trip, pump_fault, electrical_fault} = 4'h0;
            repeat (20) @(negedge clk);
            send(CMD_STATUS_PRIMARY, '0);
            send(CMD_STATUS_PRIMARY, '0);
            chk(32'(r[S_SHUTDOWN]), 32'h0);
            chk(32'({bridge_enable, motor_clk_enable, pump_enable}), 32'h7);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Both ends leave reset together so the boot read is not missed
    initial begin
        repeat (20) @(negedge clk);
        srst = 1'b0;
        t_switch();
        t_move();
        t_ref();
        t_fault();
        finish_test();
    end
endmodule
